// [aoc_pkg.sv]
// Shared constants for the converter output control register block.
package aoc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices and byte addresses (byte address is four times the index).
  localparam logic [7:0] IDX_OUT_PWR = 8'h01;
  localparam logic [7:0] IDX_PAT_LAT = 8'h02;
  localparam logic [7:0] IDX_WAIT_HI = 8'h03;
  localparam logic [7:0] IDX_CUSTOM = 8'h05;
  localparam logic [7:0] IDX_STATUS = 8'h08;
  localparam logic [11:0] ADDR_OUT_PWR = {2'h0, IDX_OUT_PWR, 2'h0};
  localparam logic [11:0] ADDR_PAT_LAT = {2'h0, IDX_PAT_LAT, 2'h0};
  localparam logic [11:0] ADDR_WAIT_HI = {2'h0, IDX_WAIT_HI, 2'h0};
  localparam logic [11:0] ADDR_CUSTOM = {2'h0, IDX_CUSTOM, 2'h0};
  localparam logic [11:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};

  ////////////////////////////////////////////////////////////////////////////
  // Field positions in output_power_config.
  localparam int BIT_MERGE = 14;
  localparam int BIT_SER_DIS = 5;
  localparam int BIT_PDN = 0;
  // Field positions in pattern_latency_config.
  localparam int FRM_PAT_LSB = 13;
  localparam int BIT_SHORT = 12;
  localparam int BIT_AVG = 11;
  localparam int BIT_FRM_RND = 10;
  localparam int DAT_PAT_LSB = 7;
  localparam int BIT_GBL_RND = 6;
  localparam int WAIT_LO_LSB = 0;
  localparam int WAIT_LO_W = 6;
  // Upper wait bits sit at bits 10-9 of the next register.
  localparam int WAIT_HI_LSB = 9;
  // Status register fields.
  localparam int STAT_WAITING = 0;
  localparam int STAT_CNT_LSB = 1;
  localparam int STAT_FIFO = 9;
  localparam int STAT_LANE_EN = 10;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset; bits 4 and 2 of output_power_config are write-only ones.
  localparam logic [15:0] OUT_PWR_RST = 16'h0014;
  localparam logic [15:0] OUT_PWR_WO_MASK = 16'h0014;
  localparam logic [15:0] PAT_LAT_RST = 16'h0000;
  localparam logic [1:0] WAIT_HI_RST = 2'h0;
  localparam logic [13:0] CUSTOM_RST = 14'h0000;
  localparam logic [22:0] PRBS_SEED = 23'h7FFFFF;

  ////////////////////////////////////////////////////////////////////////////
  // Sample geometry and buffering.
  localparam int SAMPLE_W = 14;
  localparam int FIFO_DEPTH = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Pattern select encoding shared by data lines and frame line.
  localparam logic [2:0] PAT_NORMAL = 3'h0;
  localparam logic [2:0] PAT_SYNC = 3'h1;
  localparam logic [2:0] PAT_ALT = 3'h2;
  localparam logic [2:0] PAT_CUSTOM = 3'h3;
  localparam logic [2:0] PAT_ONES = 3'h4;
  localparam logic [2:0] PAT_TOGGLE = 3'h5;
  localparam logic [2:0] PAT_ZEROS = 3'h6;
  localparam logic [2:0] PAT_RAMP = 3'h7;
  localparam logic [13:0] WORD_SYNC = 14'h007F;
  localparam logic [13:0] WORD_ALT = 14'h1555;
  localparam logic [13:0] WORD_ALT_INV = 14'h2AAA;
  localparam logic [13:0] WORD_ONES = 14'h3FFF;
  localparam logic [13:0] WORD_ZEROS = 14'h0000;

  // Maps a pattern select onto the word driven in one sample slot.
  function automatic logic [13:0] pattern_word(input logic [2:0] sel, input logic [13:0] data,
                                               input logic [13:0] custom,
                                               input logic [13:0] ramp, input logic toggle);
    case (sel)
      PAT_NORMAL: pattern_word = data;
      PAT_SYNC: pattern_word = WORD_SYNC;
      PAT_ALT: pattern_word = WORD_ALT;
      PAT_CUSTOM: pattern_word = custom;
      PAT_ONES: pattern_word = WORD_ONES;
      PAT_TOGGLE: pattern_word = toggle ? WORD_ALT_INV : WORD_ALT;
      PAT_ZEROS: pattern_word = WORD_ZEROS;
      PAT_RAMP: pattern_word = ramp;
      default: pattern_word = data;
    endcase
  endfunction

endpackage

// [aoc_fifo.sv]
// Small first-in first-out buffer for sample pairs.
`timescale 1ns/100ps
`default_nettype none
module aoc_fifo #(
  parameter int W = 28,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } aoc_fifo_s;

  aoc_fifo_s s_q;
  aoc_fifo_s s_d;
  logic push;
  logic pop;

  // Honest flags straight from the occupancy count.
  assign in_ready = (s_q.cnt != FULL_CNT);
  assign out_valid = (s_q.cnt != '0);
  assign out_data = s_q.mem[s_q.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Next state: write at the tail, read at the head, count both.
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = in_data;
      s_d.wr = s_q.wr + 1'b1;
    end
    if (pop) begin
      s_d.rd = s_q.rd + 1'b1;
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

// [aoc_prbs.sv]
// Pseudo-random word source for the test pattern paths.
`timescale 1ns/100ps
`default_nettype none
module aoc_prbs (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Step control and word out.
  input wire logic advance,
  output logic [13:0] word
);
  typedef struct packed {
    logic [22:0] lfsr;
  } aoc_prbs_s;

  aoc_prbs_s s_q;
  aoc_prbs_s s_d;

  assign word = s_q.lfsr[13:0];

  // Fourteen steps of the x^23 + x^18 + 1 sequence per sample slot.
  always_comb begin
    s_d = s_q;
    if (advance) begin
      for (int i = 0; i < 14; i++) begin
        s_d.lfsr = {s_d.lfsr[21:0], s_d.lfsr[22] ^ s_d.lfsr[17]};
      end
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{lfsr: aoc_pkg::PRBS_SEED};
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

// [aoc_top.sv]
// Output control registers and per-slot word selection for the serial outputs.
//
// The APB register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module aoc_top (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sample pairs from the conversion core.
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic [27:0] sample_pair,
  // Pins from outside.
  input wire logic link_clk_in,
  input wire logic transmit_trigger_input,
  // Words to the serializer.
  output logic [13:0] lane0_word,
  output logic [13:0] lane1_word,
  output logic [13:0] frame_word,
  output logic word_valid,
  output logic lane_enable,
  // Core controls.
  output logic conv_powerdown,
  output logic digital_bypass,
  output logic offset_fix_start
);
  typedef enum logic {WAIT_IDLE, WAIT_RUN} aoc_wait_e;

  typedef struct packed {
    logic [15:0] out_pwr;
    logic [15:0] pat_lat;
    logic [1:0] wait_hi;
    logic [13:0] custom;
    logic [31:0] prdata;
    logic slverr;
    logic [2:0] lclk_sync;
    logic [2:0] trig_sync;
    aoc_wait_e wstate;
    logic [7:0] wait_cnt;
    logic fix_start;
    logic [13:0] lane0;
    logic [13:0] lane1;
    logic [13:0] frame;
    logic word_valid;
    logic lane_en;
    logic merge_phase;
    logic [27:0] held;
    logic [13:0] ramp;
    logic toggle;
  } aoc_state_s;

  aoc_state_s s_q;
  aoc_state_s s_d;
  logic fifo_valid;
  logic fifo_ready;
  logic [27:0] fifo_data;
  logic [13:0] prbs_word;
  logic slot;
  logic trig_edge;
  logic pdn;
  logic dis;
  logic live;
  logic merge;
  logic short_path;
  logic avg_on;
  logic gbl_rnd;
  logic frm_rnd;
  logic lane1_used;
  logic [2:0] dsel;
  logic [2:0] fsel;
  logic [7:0] delay;
  logic setup;
  logic access;
  logic mapped;
  logic [31:0] rd_mux;
  logic [13:0] ch_a;
  logic [13:0] ch_b;
  logic [14:0] pair_sum;

  ////////////////////////////////////////////////////////////////////////////
  // Sample buffer; it fills while slots are slow or output is stalled.
  aoc_fifo #(.W(28), .DEPTH(aoc_pkg::FIFO_DEPTH)) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .in_data(sample_pair),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_data)
  );

  // Pseudo-random source steps once per live slot.
  aoc_prbs u_prbs (
    .pclk(pclk),
    .presetn(presetn),
    .advance(slot && live),
    .word(prbs_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decoded controls from the output, pattern/latency and wait-high registers.
  assign pdn = s_q.out_pwr[aoc_pkg::BIT_PDN];
  assign dis = s_q.out_pwr[aoc_pkg::BIT_SER_DIS];
  assign live = !pdn && !dis;
  assign merge = s_q.out_pwr[aoc_pkg::BIT_MERGE];
  assign short_path = s_q.pat_lat[aoc_pkg::BIT_SHORT];
  assign avg_on = s_q.pat_lat[aoc_pkg::BIT_AVG] && !short_path;
  assign gbl_rnd = s_q.pat_lat[aoc_pkg::BIT_GBL_RND];
  assign frm_rnd = s_q.pat_lat[aoc_pkg::BIT_FRM_RND];
  assign dsel = s_q.pat_lat[aoc_pkg::DAT_PAT_LSB +: 3];
  assign fsel = s_q.pat_lat[aoc_pkg::FRM_PAT_LSB +: 3];
  assign delay = {s_q.wait_hi, s_q.pat_lat[aoc_pkg::WAIT_LO_LSB +: aoc_pkg::WAIT_LO_W]};
  assign lane1_used = !merge && !avg_on;

  // Slot and trigger edges read only the second and third sync stages.
  assign slot = s_q.lclk_sync[1] && !s_q.lclk_sync[2];
  assign trig_edge = s_q.trig_sync[1] && !s_q.trig_sync[2];

  // In merge mode the second half of a pair comes from the held word, so no pop.
  assign fifo_ready = slot && live && !(merge && !avg_on && s_q.merge_phase);

  // Channel split and the two-channel mean.
  assign ch_a = fifo_valid ? fifo_data[13:0] : aoc_pkg::WORD_ZEROS;
  assign ch_b = fifo_valid ? fifo_data[27:14] : aoc_pkg::WORD_ZEROS;
  assign pair_sum = {1'b0, ch_a} + {1'b0, ch_b};

  ////////////////////////////////////////////////////////////////////////////
  // APB phases and read decode.
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign mapped = (paddr == aoc_pkg::ADDR_OUT_PWR) || (paddr == aoc_pkg::ADDR_PAT_LAT) ||
                  (paddr == aoc_pkg::ADDR_WAIT_HI) || (paddr == aoc_pkg::ADDR_CUSTOM) ||
                  (paddr == aoc_pkg::ADDR_STATUS);

  // Read data mux; write-only bits read back as zero.
  always_comb begin
    rd_mux = 32'h00000000;
    case (paddr)
      aoc_pkg::ADDR_OUT_PWR: rd_mux[15:0] = s_q.out_pwr & ~aoc_pkg::OUT_PWR_WO_MASK;
      aoc_pkg::ADDR_PAT_LAT: rd_mux[15:0] = s_q.pat_lat;
      aoc_pkg::ADDR_WAIT_HI: rd_mux[aoc_pkg::WAIT_HI_LSB +: 2] = s_q.wait_hi;
      aoc_pkg::ADDR_CUSTOM: rd_mux[13:0] = s_q.custom;
      aoc_pkg::ADDR_STATUS: begin
        rd_mux[aoc_pkg::STAT_WAITING] = (s_q.wstate == WAIT_RUN);
        rd_mux[aoc_pkg::STAT_CNT_LSB +: 8] = s_q.wait_cnt;
        rd_mux[aoc_pkg::STAT_FIFO] = fifo_valid;
        rd_mux[aoc_pkg::STAT_LANE_EN] = s_q.lane_en;
      end
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Zero-wait slave: answer is ready in every access phase.
  assign pready = 1'b1;
  assign prdata = s_q.prdata;
  assign pslverr = access && s_q.slverr;

  ////////////////////////////////////////////////////////////////////////////
  // Next state of the whole block.
  always_comb begin
    s_d = s_q;
    s_d.fix_start = 1'b0;
    s_d.word_valid = 1'b0;
    s_d.lclk_sync = {s_q.lclk_sync[1:0], link_clk_in};
    s_d.trig_sync = {s_q.trig_sync[1:0], transmit_trigger_input};

    // Register access: read data and error are caught in the setup phase.
    if (setup) begin
      s_d.prdata = rd_mux;
      s_d.slverr = !mapped || (pwrite && paddr == aoc_pkg::ADDR_STATUS);
    end
    if (access && pwrite && !s_q.slverr) begin
      case (paddr)
        aoc_pkg::ADDR_OUT_PWR: s_d.out_pwr = pwdata[15:0];
        aoc_pkg::ADDR_PAT_LAT: s_d.pat_lat = pwdata[15:0];
        aoc_pkg::ADDR_WAIT_HI: s_d.wait_hi = pwdata[aoc_pkg::WAIT_HI_LSB +: 2];
        aoc_pkg::ADDR_CUSTOM: s_d.custom = pwdata[13:0];
        default: s_d.custom = s_q.custom;
      endcase
    end

    // Offset correction wait, counted in sample slots.
    case (s_q.wstate)
      WAIT_IDLE: begin
        if (trig_edge && !pdn) begin
          s_d.wstate = WAIT_RUN;
          s_d.wait_cnt = delay;
        end
      end
      WAIT_RUN: begin
        if (pdn) begin
          s_d.wstate = WAIT_IDLE;
        end else if (trig_edge) begin
          s_d.wait_cnt = delay;
        end else if (slot) begin
          if (s_q.wait_cnt == 8'h00) begin
            s_d.fix_start = 1'b1;
            s_d.wstate = WAIT_IDLE;
          end else begin
            s_d.wait_cnt = s_q.wait_cnt - 8'h01;
          end
        end
      end
      default: s_d.wstate = WAIT_IDLE;
    endcase

    // Output words: interface off or powered down silences every lane.
    if (!live) begin
      s_d.lane0 = aoc_pkg::WORD_ZEROS;
      s_d.lane1 = aoc_pkg::WORD_ZEROS;
      s_d.frame = aoc_pkg::WORD_ZEROS;
      s_d.lane_en = 1'b0;
      s_d.merge_phase = 1'b0;
    end else if (slot) begin
      s_d.lane_en = 1'b1;
      s_d.word_valid = 1'b1;
      s_d.ramp = s_q.ramp + 14'h0001;
      s_d.toggle = !s_q.toggle;
      if (avg_on) begin
        s_d.lane0 = pair_sum[14:1];
      end else if (merge) begin
        s_d.merge_phase = !s_q.merge_phase;
        if (s_q.merge_phase) begin
          s_d.lane0 = s_q.held[27:14];
        end else begin
          s_d.lane0 = ch_a;
          s_d.held = {ch_b, ch_a};
        end
      end else begin
        s_d.lane0 = ch_a;
      end
      s_d.lane1 = lane1_used ? ch_b : aoc_pkg::WORD_ZEROS;
      // Test patterns replace the data words on the data lanes.
      if (gbl_rnd) begin
        s_d.lane0 = prbs_word;
        s_d.lane1 = lane1_used ? prbs_word : aoc_pkg::WORD_ZEROS;
      end else begin
        s_d.lane0 = aoc_pkg::pattern_word(dsel, s_d.lane0, s_q.custom, s_q.ramp,
                                          s_q.toggle);
        if (lane1_used) begin
          s_d.lane1 = aoc_pkg::pattern_word(dsel, s_d.lane1, s_q.custom, s_q.ramp,
                                            s_q.toggle);
        end
      end
      // Frame line: normal frame is half zeros, half ones.
      if (frm_rnd) begin
        s_d.frame = ~prbs_word;
      end else begin
        s_d.frame = aoc_pkg::pattern_word(fsel, aoc_pkg::WORD_SYNC, s_q.custom, s_q.ramp,
                                          s_q.toggle);
      end
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.out_pwr <= aoc_pkg::OUT_PWR_RST;
      s_q.pat_lat <= aoc_pkg::PAT_LAT_RST;
      s_q.wait_hi <= aoc_pkg::WAIT_HI_RST;
      s_q.custom <= aoc_pkg::CUSTOM_RST;
      s_q.wstate <= WAIT_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops.
  assign lane0_word = s_q.lane0;
  assign lane1_word = s_q.lane1;
  assign frame_word = s_q.frame;
  assign word_valid = s_q.word_valid;
  assign lane_enable = s_q.lane_en;
  assign conv_powerdown = pdn;
  assign digital_bypass = short_path;
  assign offset_fix_start = s_q.fix_start;

  ////////////////////////////////////////////////////////////////////////////
  // Checks next to the logic they guard.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_merge_one_lane: assert property (
    word_valid && $past(merge && !avg_on) |-> lane1_word == aoc_pkg::WORD_ZEROS)
    else $error("Merged mode left the second lane busy.");

  chk_serial_off: assert property (
    dis [*2] |-> (!lane_enable && !word_valid) [*2])
    else $error("Serial outputs still active while disabled.");

  chk_full_pdn: assert property (
    pdn && slot |=> !word_valid && !offset_fix_start && lane0_word == aoc_pkg::WORD_ZEROS)
    else $error("Words produced during power-down.");

  chk_frame_ones: assert property (
    word_valid && $past(!frm_rnd && fsel == aoc_pkg::PAT_ONES)
    |-> frame_word == aoc_pkg::WORD_ONES)
    else $error("Frame line does not show the selected pattern.");

  chk_short_bypass: assert property (
    word_valid && $past(short_path && !merge && !gbl_rnd && dsel == aoc_pkg::PAT_NORMAL)
    |-> lane1_word == $past(ch_b))
    else $error("Short path did not bypass averaging.");

  chk_pair_mean: assert property (
    word_valid && $past(avg_on && !gbl_rnd && dsel == aoc_pkg::PAT_NORMAL)
    |-> lane0_word == $past(pair_sum[14:1]) && lane1_word == aoc_pkg::WORD_ZEROS)
    else $error("Averaged lane does not hold the pair mean.");

  chk_frame_random: assert property (
    word_valid && $past(frm_rnd) |-> frame_word == ~$past(prbs_word))
    else $error("Frame line is not the random sequence.");

  chk_data_zeros: assert property (
    word_valid && $past(!gbl_rnd && dsel == aoc_pkg::PAT_ZEROS)
    |-> lane0_word == aoc_pkg::WORD_ZEROS)
    else $error("Data lanes ignore the zeros pattern.");

  chk_data_alt: assert property (
    word_valid && $past(!gbl_rnd && dsel == aoc_pkg::PAT_ALT)
    |-> lane0_word == aoc_pkg::WORD_ALT)
    else $error("Alternate pattern word is wrong.");

  chk_global_random: assert property (
    word_valid && $past(gbl_rnd) |-> lane0_word == $past(prbs_word))
    else $error("Data lanes are not the random sequence.");

  chk_offset_load: assert property (
    trig_edge && !pdn |=> s_q.wstate == WAIT_RUN && s_q.wait_cnt == $past(delay))
    else $error("Trigger did not load the offset wait.");

  chk_offset_fire: assert property (
    offset_fix_start |-> $past(s_q.wstate == WAIT_RUN && s_q.wait_cnt == 8'h00 && slot))
    else $error("Offset correction started at the wrong slot.");
endmodule
`default_nettype wire

// [aoc_link_rx.sv]
// Receiver-side model: runs the link clock and counts words seen.
`timescale 1ns/100ps
`default_nettype none
module aoc_link_rx (
  // Bench clock.
  input wire logic pclk,
  // Link clock toward the device.
  output logic link_clk,
  // Words from the device.
  input wire logic word_valid,
  output logic [31:0] word_count
);
  // An 800 ns link clock, offset so its edges never meet the pclk edges.
  initial begin
    link_clk = 1'b0;
    #137;
    forever #400 link_clk = ~link_clk;
  end
  // Count of words that the receiver captured.
  initial word_count = 32'h0;
  always @(posedge pclk) begin
    if (word_valid === 1'b1) begin
      word_count <= word_count + 32'h1;
    end
  end
endmodule
`default_nettype wire

// [tb_adc_output_control_regs.sv]
// Self-checking bench for the converter output control register block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin fail_count++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_adc_output_control_regs;
  logic pclk, presetn, psel, penable, pwrite, sample_valid, sample_ready, link_clk, trig;
  logic pready, pslverr, word_valid, lane_enable, conv_pd, bypass, fix_start, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, word_count, p, n0;
  logic [27:0] sample_pair, exp_w;
  logic [13:0] lane0, lane1, frame, w1, f1, cust;
  logic [27:0] expq[$];
  int fail_count, total_checks;

  aoc_top i_aoc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_valid(sample_valid), .sample_ready(sample_ready),
    .sample_pair(sample_pair), .link_clk_in(link_clk), .transmit_trigger_input(trig),
    .lane0_word(lane0), .lane1_word(lane1), .frame_word(frame), .word_valid(word_valid),
    .lane_enable(lane_enable), .conv_powerdown(conv_pd), .digital_bypass(bypass),
    .offset_fix_start(fix_start));
  aoc_link_rx i_aoc_link_rx (.pclk(pclk), .link_clk(link_clk), .word_valid(word_valid),
    .word_count(word_count));

  ////////////////////////////////////////////////////////////////////////////
  // Clock of 100 ns and a cycle ceiling that cuts a hang short.
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    finish_test();
  end

  // One APB transfer; read data and error are taken where pready is high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Hands one sample pair to the buffer and waits until it is taken.
  task automatic push(input logic [27:0] s);
    @(posedge pclk);
    sample_valid <= 1'b1;
    sample_pair <= s;
    do @(posedge pclk); while (sample_ready !== 1'b1);
    sample_valid <= 1'b0;
  endtask

  // Waits for the cycle that carries fresh lane words.
  task automatic next_word();
    do @(posedge pclk); while (word_valid !== 1'b1);
  endtask

  // Word expected in the slot after word w for a given pattern code.
  function automatic logic [13:0] pat(input int c, input logic [13:0] w);
    case (c)
      1: pat = 14'h007F;
      2: pat = 14'h1555;
      3: pat = cust;
      4: pat = 14'h3FFF;
      5: pat = w ^ 14'h3FFF;
      7: pat = w + 14'h1;
      default: pat = 14'h0000;
    endcase
  endfunction

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    {presetn, psel, penable, pwrite, sample_valid, trig} = 6'h00;
    {paddr, pwdata, sample_pair} = 72'h0;
    void'($urandom(86792));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values read zero; write-only ones of the first register read zero.
    for (int i = 1; i < 4; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      `CHK("reset value", 32'h0, rd)
    end
    // Unmapped place and the read-only status word refuse writes.
    apb(1'b1, 12'h3FC, 32'h1);
    `CHK("unmapped error", 1'b1, err)
    apb(1'b1, aoc_pkg::ADDR_STATUS, 32'h1);
    `CHK("status write error", 1'b1, err)
    // Random pattern/latency word reads back and drives the bypass level.
    p = {16'h0, 16'($urandom)};
    apb(1'b1, aoc_pkg::ADDR_PAT_LAT, p);
    apb(1'b0, aoc_pkg::ADDR_PAT_LAT, 32'h0);
    `CHK("pattern readback", p, rd)
    `CHK("bypass", p[12], bypass)
    // Every mix of merge, disable and power-down in the first register.
    for (int i = 0; i < 8; i++) begin
      p = 32'h0014 | 32'(i[0]) | (32'(i[1]) << 5) | (32'(i[2]) << 14);
      apb(1'b1, aoc_pkg::ADDR_OUT_PWR, p);
      apb(1'b0, aoc_pkg::ADDR_OUT_PWR, 32'h0);
      `CHK("out_pwr readback", p & 32'hFFEB, rd)
      `CHK("powerdown", i[0], conv_pd)
      if (i[1:0] != 2'h0) begin
        `CHK("lanes off", 1'b0, lane_enable)
      end
    end
    // Fill the buffer while disabled, then drain in normal, average, merge and bypass modes.
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, aoc_pkg::ADDR_PAT_LAT, (m == 1) ? 32'h0800 : (m == 3) ? 32'h1800 : 32'h0);
      apb(1'b1, aoc_pkg::ADDR_OUT_PWR, (m == 2) ? 32'h4034 : 32'h0034);
      for (int k = 0; k < 4; k++) begin
        p = $urandom;
        push(p[27:0]);
        if (m == 0 || m == 3) expq.push_back(p[27:0]);
        if (m == 1) expq.push_back({14'h0, 14'((15'(p[13:0]) + 15'(p[27:14])) >> 1)});
        if (m == 2) expq.push_back({14'h0, p[13:0]});
        if (m == 2) expq.push_back({14'h0, p[27:14]});
      end
      @(posedge pclk);
      `CHK("buffer full", 1'b0, sample_ready)
      apb(1'b1, aoc_pkg::ADDR_OUT_PWR, (m == 2) ? 32'h4014 : 32'h0014);
      while (expq.size() > 0) begin
        next_word();
        exp_w = expq.pop_front();
        `CHK("lane words", exp_w, {lane1, lane0})
      end
      next_word();
      `CHK("empty buffer word", 14'h0, lane0)
    end
    // Every pattern code on data lanes and frame line together.
    cust = 14'($urandom);
    apb(1'b1, aoc_pkg::ADDR_CUSTOM, {18'h0, cust});
    apb(1'b0, aoc_pkg::ADDR_CUSTOM, 32'h0);
    `CHK("custom readback", {18'h0, cust}, rd)
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, aoc_pkg::ADDR_PAT_LAT, 32'((c << 13) | (c << 7)));
      next_word();
      next_word();
      w1 = lane0;
      f1 = frame;
      next_word();
      `CHK("data pattern", pat(c, w1), lane0)
      `CHK("frame pattern", (c == 0) ? 14'h007F : pat(c, f1), frame)
    end
    // Pseudo-random words on lanes, inverted copy on the frame line.
    apb(1'b1, aoc_pkg::ADDR_PAT_LAT, 32'h0440);
    next_word();
    next_word();
    w1 = lane0;
    `CHK("random frame", 14'h3FFF, lane0 ^ frame)
    next_word();
    `CHK("random steps", 1'b1, lane0 !== w1)
    // Delay of 65 samples split across both registers.
    apb(1'b1, aoc_pkg::ADDR_WAIT_HI, 32'h0200);
    apb(1'b0, aoc_pkg::ADDR_WAIT_HI, 32'h0);
    `CHK("wait high readback", 32'h0200, rd)
    apb(1'b1, aoc_pkg::ADDR_PAT_LAT, 32'h0001);
    next_word();
    trig <= 1'b1;
    @(posedge pclk);
    n0 = word_count;
    // The wait must show as running with the lanes up and the buffer empty.
    repeat (4) @(posedge pclk);
    apb(1'b0, aoc_pkg::ADDR_STATUS, 32'h0);
    `CHK("status waiting", 32'h401, rd & 32'h601)
    do @(posedge pclk); while (fix_start !== 1'b1);
    `CHK("trigger slots", 32'd66, word_count - n0 + 32'(word_valid))
    trig <= 1'b0;
    finish_test();
  end
endmodule
`default_nettype wire
